// >>> pcc_config.v
// Configuration command, status and base address logic of the target card
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defines.vh"
// ****************************************************************
// Notes on behaviour
// [RULE_01] Command all zeros: no response to any access except configuration.
// [RULE_02] Command bit 0 enables I/O space response; resets to zero.
// [RULE_03] Command bit 1 enables memory space response; resets to zero.
// [RULE_04] Command bit 2 permits bus mastering; zero means no accesses generated.
// [RULE_05] Command bit 3 makes special cycles monitored; zero ignores them.
// [RULE_06] Command bit 4 allows memory-write-and-invalidate; resets to zero.
// [RULE_07] Command bit 5 enables palette snooping: palette accesses not claimed.
// [RULE_08] Command bit 6 enables parity error response; parity still generated.
// [RULE_09] Command bit 7 shows stepping: fixed zero, fixed one, or writable reset one.
// [RULE_10] Command bit 8 enables system error driver; address parity needs 8 and 6.
// [RULE_11] Command bit 9 allows fast back-to-back to different agents.
// [RULE_12] Status reads normally; writing one clears a bit, never sets.
// [RULE_13] Status bit 7 is fixed: one only if fast back-to-back capable.
// [RULE_14] Status bit 8 set on mastered parity error while bit 6 set.
// [RULE_15] Status bits 10:9 give slowest device-select timing, fixed.
// [RULE_16] Status bit 11 set when target ends transfer with target abort.
// [RULE_17] Status bit 12 set when own master transfer gets target abort.
// [RULE_18] Status bit 13 set on master abort, special cycles excluded.
// [RULE_19] Status bit 14 set each time system error is asserted.
// [RULE_20] Status bit 15 set on any detected parity error regardless of bit 6.
// [RULE_21] I/O base register: bit 0 reads one, bit 1 reads zero.
// [RULE_22] Memory base: bit 0 zero, bits 2:1 type, bit 3 prefetch, all read-only.
// [RULE_23] Undecoded address bits read zero so all-ones sizing shows size.
// [RULE_24] Claims a relocatable 64-byte I/O window, no waits, no interrupts.
// [RULE_25] Reserved command and status bits read zero and ignore writes.
// ****************************************************************
module pcc_config #(
  parameter [1:0] STEPPING     = `PCC_STEP_NEVER,
  parameter [1:0] DEVSEL_SPEED = `PCC_DEVSEL_MEDIUM,
  parameter       FBB_CAPABLE  = 0,
  parameter [1:0] MEM_TYPE     = `PCC_MEM_TYPE_32,
  parameter       PREFETCH     = 0,
  parameter       IO_BITS      = `PCC_IO_SIZE_BITS,
  parameter       MEM_BITS     = `PCC_MEM_SIZE_BITS
) (
  input  wire        mclk,
  input  wire        reset,
  // Configuration access port
  input  wire        cfg_write,
  input  wire        cfg_read,
  input  wire [5:0]  cfg_dword,
  input  wire [3:0]  cfg_byte_en,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata,
  output reg         cfg_rvalid,
  // Address phase of ordinary bus accesses
  input  wire        acc_valid,
  input  wire        acc_is_io,
  input  wire        acc_is_mem,
  input  wire        acc_palette,
  input  wire [31:0] acc_addr,
  output reg         acc_claim,
  // Special cycle monitor
  input  wire        special_cycle,
  output reg         special_seen,
  // Bus events
  input  wire        ev_target_abort_sent,
  input  wire        ev_master_tabort_rcvd,
  input  wire        ev_master_abort,
  input  wire        ev_master_special,
  input  wire        ev_perr_mastered,
  input  wire        ev_data_parity_err,
  input  wire        ev_addr_parity_err,
  // System error open-drain pin
  output reg         serr_out,
  output reg         serr_oe,
  // Controls toward the master and parity logic
  output reg         master_enable,
  output reg         mwi_enable,
  output reg         fbb_enable,
  output reg         parity_resp_enable,
  output reg         step_enable
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [31:0] pcc_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  be;
    integer i;
    begin
      pcc_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          pcc_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // Mask of decoded address bits for a window of 2**bits bytes
  function [31:0] pcc_size_mask;
    input integer bits;
    begin
      pcc_size_mask = 32'hFFFFFFFF << bits;
    end
  endfunction

  localparam [31:0] IO_MASK  = pcc_size_mask(IO_BITS);
  localparam [31:0] MEM_MASK = pcc_size_mask(MEM_BITS);
  localparam [31:0] MEM_LOW  = {28'h0000000, (PREFETCH != 0), MEM_TYPE, 1'b0};
  localparam [31:0] IO_LOW   = {30'h00000000, `PCC_IO_BAR_LOW};
  localparam        STEP_RW  = (STEPPING == `PCC_STEP_BOTH);
  localparam        STEP_ONE = (STEPPING == `PCC_STEP_ALWAYS);
  // Stepping bit leaves reset at one when it is fixed one or writable
  localparam [15:0] CMD_RESET = `PCC_CMD_RESET | {8'h00, (STEP_RW || STEP_ONE), 7'h00};

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg  [15:0] bus_command_control;
  reg  [15:0] bus_event_status;
  reg  [31:0] io_window_base;
  reg  [31:0] memory_window_base;

  reg  [15:0] next_command;
  reg  [31:0] cmd_merge;
  reg  [15:0] next_status;
  reg  [15:0] status_set;
  reg  [15:0] status_clear;
  reg  [31:0] next_io_base;
  reg  [31:0] next_mem_base;
  reg  [31:0] cmd_stat_word;
  reg         serr_fire;
  wire        wr_cmd;
  wire        wr_io;
  wire        wr_mem;
  wire        io_hit;
  wire        mem_hit;

  assign wr_cmd = cfg_write && (cfg_dword == `PCC_OFF_CMD_STAT);
  assign wr_io  = cfg_write && (cfg_dword == `PCC_OFF_IO_BAR);
  assign wr_mem = cfg_write && (cfg_dword == `PCC_OFF_MEM_BAR);

  // ****************************************************************
  // Command register
  // ****************************************************************
  always @* begin
    cmd_merge    = pcc_merge({16'h0000, bus_command_control},
                             {16'h0000, cfg_wdata[15:0]},
                             cfg_byte_en);
    next_command = bus_command_control;
    if (wr_cmd) begin
      next_command = cmd_merge[15:0] & `PCC_CMD_WMASK; // [RULE_25]
      if (STEP_RW) begin
        next_command[`PCC_CMD_STEP] = cmd_merge[`PCC_CMD_STEP]; // [RULE_09]
      end else begin
        next_command[`PCC_CMD_STEP] = STEP_ONE; // [RULE_09]
      end
    end
  end

  // ****************************************************************
  // Status events and write-one-to-clear
  // ****************************************************************
  always @* begin
    serr_fire = ev_addr_parity_err && bus_command_control[`PCC_CMD_SERR]
                && bus_command_control[`PCC_CMD_PARITY]; // [RULE_10]
    status_set = 16'h0000;
    status_set[`PCC_ST_DPERR] = ev_perr_mastered
                                && bus_command_control[`PCC_CMD_MASTER]
                                && bus_command_control[`PCC_CMD_PARITY]; // [RULE_14]
    status_set[`PCC_ST_SIG_TABORT] = ev_target_abort_sent; // [RULE_16]
    status_set[`PCC_ST_RCV_TABORT] = ev_master_tabort_rcvd
                                     && bus_command_control[`PCC_CMD_MASTER]; // [RULE_17]
    status_set[`PCC_ST_RCV_MABORT] = ev_master_abort && !ev_master_special
                                     && bus_command_control[`PCC_CMD_MASTER]; // [RULE_18]
    status_set[`PCC_ST_SIG_SERR] = serr_fire; // [RULE_19]
    status_set[`PCC_ST_DET_PERR] = ev_data_parity_err || ev_addr_parity_err; // [RULE_20]
    status_clear = 16'h0000;
    if (wr_cmd) begin
      if (cfg_byte_en[2]) begin
        status_clear[7:0] = cfg_wdata[23:16]; // [RULE_12]
      end
      if (cfg_byte_en[3]) begin
        status_clear[15:8] = cfg_wdata[31:24]; // [RULE_12]
      end
    end
    // A new event beats a clear in the same cycle
    next_status = (bus_event_status & ~status_clear) | status_set; // [RULE_12]
    next_status[7:0] = 8'h00; // [RULE_25]
    next_status[`PCC_ST_DEVSEL_HI:`PCC_ST_DEVSEL_LO] = 2'h0;
  end

  // ****************************************************************
  // Base address registers
  // ****************************************************************
  always @* begin
    next_io_base  = io_window_base;
    next_mem_base = memory_window_base;
    if (wr_io) begin
      next_io_base = pcc_merge(io_window_base, cfg_wdata, cfg_byte_en)
                     & IO_MASK; // [RULE_23] [RULE_24]
    end
    if (wr_mem) begin
      next_mem_base = pcc_merge(memory_window_base, cfg_wdata, cfg_byte_en)
                      & MEM_MASK; // [RULE_23]
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always @* begin
    cmd_stat_word = {bus_event_status, bus_command_control};
    cmd_stat_word[16 + `PCC_ST_FBB_CAP] = (FBB_CAPABLE != 0); // [RULE_13]
    cmd_stat_word[16 + `PCC_ST_DEVSEL_HI:16 + `PCC_ST_DEVSEL_LO] = DEVSEL_SPEED; // [RULE_15]
  end

  // Window hits; only the upper decoded bits are compared
  assign io_hit  = ((acc_addr & IO_MASK) == io_window_base);
  assign mem_hit = ((acc_addr & MEM_MASK) == memory_window_base);

  // ****************************************************************
  // Registers
  // ****************************************************************
  always @(posedge mclk) begin
    if (reset) begin
      bus_command_control <= CMD_RESET; // [RULE_09]
      bus_event_status    <= `PCC_ST_RESET;
      io_window_base      <= `PCC_BAR_RESET;
      memory_window_base  <= `PCC_BAR_RESET;
      cfg_rdata           <= 32'h00000000;
      cfg_rvalid          <= 1'b0;
      acc_claim           <= 1'b0;
      special_seen        <= 1'b0;
      serr_out            <= 1'b0;
      serr_oe             <= 1'b0;
      master_enable       <= 1'b0;
      mwi_enable          <= 1'b0;
      fbb_enable          <= 1'b0;
      parity_resp_enable  <= 1'b0;
      step_enable         <= CMD_RESET[`PCC_CMD_STEP];
    end else begin
      bus_command_control <= next_command; // [RULE_02] [RULE_03]
      bus_event_status    <= next_status;
      io_window_base      <= next_io_base;
      memory_window_base  <= next_mem_base;
      cfg_rvalid          <= cfg_read;
      if (cfg_read) begin
        case (cfg_dword)
          `PCC_OFF_CMD_STAT: cfg_rdata <= cmd_stat_word;
          `PCC_OFF_IO_BAR:   cfg_rdata <= io_window_base | IO_LOW; // [RULE_21]
          `PCC_OFF_MEM_BAR:  cfg_rdata <= memory_window_base | MEM_LOW; // [RULE_22]
          default:           cfg_rdata <= 32'h00000000;
        endcase
      end
      // Claim decided in one cycle: the card needs no wait states
      acc_claim <= acc_valid && !(acc_palette
                   && bus_command_control[`PCC_CMD_PALETTE]) // [RULE_07]
                   && ((acc_is_io && bus_command_control[`PCC_CMD_IO]
                        && io_hit) // [RULE_02] [RULE_24] [RULE_01]
                       || (acc_is_mem && bus_command_control[`PCC_CMD_MEM]
                           && mem_hit)); // [RULE_03] [RULE_01]
      special_seen <= special_cycle
                      && bus_command_control[`PCC_CMD_SPECIAL]; // [RULE_05]
      // Open drain: drive low for one cycle, release otherwise
      serr_out <= 1'b0;
      serr_oe  <= serr_fire; // [RULE_10] [RULE_19]
      master_enable <= next_command[`PCC_CMD_MASTER]; // [RULE_04]
      mwi_enable    <= next_command[`PCC_CMD_MWI]
                       && next_command[`PCC_CMD_MASTER]; // [RULE_06]
      fbb_enable    <= next_command[`PCC_CMD_FBB]; // [RULE_11]
      parity_resp_enable <= next_command[`PCC_CMD_PARITY]; // [RULE_08]
      step_enable   <= next_command[`PCC_CMD_STEP]; // [RULE_09]
    end
  end

endmodule // pcc_config
`default_nettype wire

// >>> pcc_defines.vh
// Constants for the configuration control block: offsets, field positions, resets
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH
// ****************************************************************
// Configuration space dword offsets (byte offset / 4)
// ****************************************************************
`define PCC_OFF_CMD_STAT   6'h01
`define PCC_OFF_MEM_BAR    6'h04
`define PCC_OFF_IO_BAR     6'h05
// ****************************************************************
// Command field positions
// ****************************************************************
`define PCC_CMD_IO         0
`define PCC_CMD_MEM        1
`define PCC_CMD_MASTER     2
`define PCC_CMD_SPECIAL    3
`define PCC_CMD_MWI        4
`define PCC_CMD_PALETTE    5
`define PCC_CMD_PARITY     6
`define PCC_CMD_STEP       7
`define PCC_CMD_SERR       8
`define PCC_CMD_FBB        9
`define PCC_CMD_RESET      16'h0000
`define PCC_CMD_WMASK      16'h037F
// ****************************************************************
// Status field positions
// ****************************************************************
`define PCC_ST_FBB_CAP     7
`define PCC_ST_DPERR       8
`define PCC_ST_DEVSEL_LO   9
`define PCC_ST_DEVSEL_HI   10
`define PCC_ST_SIG_TABORT  11
`define PCC_ST_RCV_TABORT  12
`define PCC_ST_RCV_MABORT  13
`define PCC_ST_SIG_SERR    14
`define PCC_ST_DET_PERR    15
`define PCC_ST_RESET       16'h0000
// ****************************************************************
// Devsel timing codes and stepping modes
// ****************************************************************
`define PCC_DEVSEL_FAST    2'h0
`define PCC_DEVSEL_MEDIUM  2'h1
`define PCC_DEVSEL_SLOW    2'h2
`define PCC_STEP_NEVER     2'h0
`define PCC_STEP_ALWAYS    2'h1
`define PCC_STEP_BOTH      2'h2
// ****************************************************************
// Base address register low bits, window size bits and reset value
// ****************************************************************
`define PCC_IO_BAR_LOW     2'h1
`define PCC_MEM_TYPE_32    2'h0
`define PCC_MEM_TYPE_1M    2'h1
`define PCC_MEM_TYPE_64    2'h2
`define PCC_IO_SIZE_BITS   6
`define PCC_MEM_SIZE_BITS  12
`define PCC_BAR_RESET      32'h00000000
`endif

// >>> pcc_config_checker.sv
// Port-level assertions for the configuration control block
`timescale 1ns/1ps
`default_nettype none
module pcc_config_checker (
  input wire        mclk,
  input wire        reset,
  input wire        cfg_read,
  input wire [31:0] cfg_rdata,
  input wire        cfg_rvalid,
  input wire        acc_valid,
  input wire        acc_is_io,
  input wire        acc_is_mem,
  input wire        acc_claim,
  input wire        special_cycle,
  input wire        special_seen,
  input wire        ev_addr_parity_err,
  input wire        serr_out,
  input wire        serr_oe,
  input wire        master_enable,
  input wire        mwi_enable,
  input wire        parity_resp_enable,
  input wire        step_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_read;
    cfg_read;
  endsequence
  sequence s_answer;
    cfg_rvalid;
  endsequence
  a_read_answer: assert property (s_read |=> s_answer)
    else $error("read not answered");
  a_rvalid_cause: assert property (cfg_rvalid |-> $past(cfg_read))
    else $error("answer without read");
  // Skip the edge after reset, which legally clears the data
  a_rdata_hold: assert property (!cfg_rvalid && !$past(reset) |-> $stable(cfg_rdata))
    else $error("read data moved");
  a_claim_cause: assert property (acc_claim |->
    $past(acc_valid && (acc_is_io || acc_is_mem)))
    else $error("claim without access");
  a_special_cause: assert property (special_seen |-> $past(special_cycle))
    else $error("special seen without cycle");
  a_serr_cause: assert property (serr_oe |->
    $past(ev_addr_parity_err && parity_resp_enable))
    else $error("error pin without cause");
  a_serr_low: assert property (serr_oe |-> serr_out == 1'b0)
    else $error("error pin not low");
  a_mwi_gated: assert property (mwi_enable |-> master_enable)
    else $error("invalidate without mastering");
  a_step_fixed: assert property (step_enable == 1'b0)
    else $error("stepping not fixed zero");
endmodule // pcc_config_checker
bind pcc_config pcc_config_checker chk (.mclk, .reset, .cfg_read, .cfg_rdata, .cfg_rvalid,
  .acc_valid, .acc_is_io, .acc_is_mem, .acc_claim, .special_cycle, .special_seen,
  .ev_addr_parity_err, .serr_out, .serr_oe, .master_enable, .mwi_enable,
  .parity_resp_enable, .step_enable);
`default_nettype wire

// >>> pcc_host.sv
// Host bridge model issuing configuration cycles
`timescale 1ns/1ps
`default_nettype none
module pcc_host (
  input  wire         mclk,
  output logic        cfg_write,
  output logic        cfg_read,
  output logic [5:0]  cfg_dword,
  output logic [3:0]  cfg_byte_en,
  output logic [31:0] cfg_wdata
);
  logic [31:0] exp_q[$];
  initial begin
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    cfg_dword = 6'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h00000000;
  end
  task automatic wr(input logic [5:0] d, input logic [3:0] be, input logic [31:0] v);
    @(posedge mclk);
    cfg_write <= 1'b1;
    cfg_dword <= d;
    cfg_byte_en <= be;
    cfg_wdata <= v;
    @(posedge mclk);
    cfg_write <= 1'b0;
    // Released data shows no stale value
    cfg_wdata <= ~v;
  endtask
  task automatic rd(input logic [5:0] d, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    cfg_read <= 1'b1;
    cfg_dword <= d;
    @(posedge mclk);
    cfg_read <= 1'b0;
  endtask
endmodule // pcc_host
`default_nettype wire

// >>> tb_pci_target_config_control.sv
// Testbench for the configuration control block
`timescale 1ns/1ps
`default_nettype none
module tb_pci_target_config_control;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        acc_valid = 1'b0;
  logic        acc_is_io = 1'b0;
  logic        acc_is_mem = 1'b0;
  logic        acc_palette = 1'b0;
  logic [31:0] acc_addr = 32'h00000000;
  logic        special_cycle = 1'b0;
  logic [6:0]  ev = 7'h00;
  logic [31:0] seed = 32'hC7C52051;
  logic [31:0] iob, mb, r;
  int          miscompares = 0;
  int          samples_checked = 0;
  wire         cfg_write, cfg_read, cfg_rvalid, acc_claim, special_seen, serr_out, serr_oe;
  wire         master_enable, mwi_enable, fbb_enable, parity_resp_enable, step_enable;
  wire [5:0]   cfg_dword;
  wire [3:0]   cfg_byte_en;
  wire [31:0]  cfg_wdata, cfg_rdata;
  always #2 mclk = ~mclk;
  pcc_host host (.mclk(mclk), .cfg_write(cfg_write), .cfg_read(cfg_read),
    .cfg_dword(cfg_dword), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata));
  pcc_config dut (.mclk(mclk), .reset(reset), .cfg_write(cfg_write), .cfg_read(cfg_read),
    .cfg_dword(cfg_dword), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .acc_valid(acc_valid),
    .acc_is_io(acc_is_io), .acc_is_mem(acc_is_mem), .acc_palette(acc_palette),
    .acc_addr(acc_addr), .acc_claim(acc_claim), .special_cycle(special_cycle),
    .special_seen(special_seen), .ev_target_abort_sent(ev[0]), .ev_master_tabort_rcvd(ev[1]),
    .ev_master_abort(ev[2]), .ev_master_special(ev[3]), .ev_perr_mastered(ev[4]),
    .ev_data_parity_err(ev[5]), .ev_addr_parity_err(ev[6]), .serr_out(serr_out),
    .serr_oe(serr_oe), .master_enable(master_enable), .mwi_enable(mwi_enable),
    .fbb_enable(fbb_enable), .parity_resp_enable(parity_resp_enable),
    .step_enable(step_enable));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] nrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (cfg_rvalid === 1'b1) begin
      if (host.exp_q.size() == 0)
        check({31'h00000000, cfg_rvalid}, 32'h00000000);
      else
        check(cfg_rdata, host.exp_q.pop_front());
    end
  end
  task acc(input logic [15:0] c, input logic io, input logic pal, input logic [31:0] a,
           input logic e);
    host.wr(6'h01, 4'h3, {16'h0000, c});
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_is_io <= io;
    acc_is_mem <= ~io;
    acc_palette <= pal;
    acc_addr <= a;
    @(posedge mclk);
    acc_valid <= 1'b0;
    acc_addr <= ~a;
    #1 check(32'(acc_claim), 32'(e));
  endtask
  task spc(input logic [15:0] c, input logic e);
    host.wr(6'h01, 4'h3, {16'h0000, c});
    @(posedge mclk);
    special_cycle <= 1'b1;
    @(posedge mclk);
    special_cycle <= 1'b0;
    #1 check(32'(special_seen), 32'(e));
  endtask
  // Clear mask cm is written to the status half; devsel bits are read-only
  task evt(input logic [15:0] c, input logic [6:0] m, input logic [15:0] st, input logic s,
           input logic [15:0] cm);
    host.wr(6'h01, 4'h3, {16'h0000, c});
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 7'h00;
    #1 check(32'(serr_oe), 32'(s));
    host.rd(6'h01, {st, c});
    host.wr(6'h01, 4'hC, {cm, 16'h0000});
    host.rd(6'h01, {(st & ~cm) | 16'h0200, c});
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    host.rd(6'h01, 32'h02000000);
    host.rd(6'h05, 32'h00000001);
    host.rd(6'h04, 32'h00000000);
    host.wr(6'h02, 4'hF, 32'hFFFFFFFF);
    host.rd(6'h02, 32'h00000000);
    host.wr(6'h01, 4'hF, 32'hFFFFFFFF);
    #1 r = {27'h0000000, master_enable, mwi_enable, fbb_enable, parity_resp_enable, step_enable};
    check(r, 32'h0000001E);
    host.rd(6'h01, 32'h0200037F);
    host.wr(6'h01, 4'h3, 32'h00000010);
    #1 check(32'({master_enable, mwi_enable}), 32'h0);
    $display("test command done");
    host.wr(6'h05, 4'hF, 32'hFFFFFFFF);
    host.wr(6'h04, 4'hF, 32'hFFFFFFFF);
    host.rd(6'h05, 32'hFFFFFFC1);
    host.rd(6'h04, 32'hFFFFF000);
    iob = nrand();
    mb = nrand();
    host.wr(6'h05, 4'hF, iob);
    host.wr(6'h04, 4'hF, mb);
    iob = iob & 32'hFFFFFFC0;
    mb = mb & 32'hFFFFF000;
    host.rd(6'h05, iob | 32'h1);
    host.rd(6'h04, mb);
    $display("test sizing done");
    r = nrand();
    acc(16'h0001, 1'b1, 1'b0, iob | (r & 32'h3F), 1'b1);
    acc(16'h0001, 1'b1, 1'b0, iob ^ 32'h40, 1'b0);
    acc(16'h0002, 1'b1, 1'b0, iob, 1'b0);
    acc(16'h0002, 1'b0, 1'b0, mb | (r & 32'hFFF), 1'b1);
    acc(16'h0001, 1'b0, 1'b0, mb, 1'b0);
    acc(16'h0023, 1'b1, 1'b1, iob, 1'b0);
    acc(16'h0003, 1'b1, 1'b1, iob, 1'b1);
    acc(16'h0000, 1'b1, 1'b0, iob, 1'b0);
    host.rd(6'h05, iob | 32'h1);
    spc(16'h0008, 1'b1);
    spc(16'h0000, 1'b0);
    $display("test decode done");
    evt(16'h037F, 7'h01, 16'h0A00, 1'b0, 16'hFFFF);
    evt(16'h037F, 7'h02, 16'h1200, 1'b0, 16'hFFFF);
    evt(16'h037F, 7'h04, 16'h2200, 1'b0, 16'hFFFF);
    evt(16'h037F, 7'h0C, 16'h0200, 1'b0, 16'hFFFF);
    evt(16'h037F, 7'h30, 16'h8300, 1'b0, 16'hFFFF);
    evt(16'h037F, 7'h40, 16'hC200, 1'b1, 16'hFFFF);
    evt(16'h0000, 7'h36, 16'h8200, 1'b0, 16'hFFFF);
    evt(16'h0100, 7'h40, 16'h8200, 1'b0, 16'hFFFF);
    evt(16'h0040, 7'h40, 16'h8200, 1'b0, 16'hFFFF);
    evt(16'h037F, 7'h07, 16'h3A00, 1'b0, 16'h0800);
    $display("test events done");
    // Let the last read drain before the bus reset swallows it
    repeat (4) @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    host.rd(6'h01, 32'h02000000);
    // Event and write-one clear on one edge: the event must survive
    fork
      host.wr(6'h01, 4'hC, 32'h08000000);
      begin
        @(posedge mclk);
        ev <= 7'h01;
        @(posedge mclk);
        ev <= 7'h00;
      end
    join
    host.rd(6'h01, 32'h0A000000);
    $display("test reset done");
    for (int i = 0; i < 8 && host.exp_q.size() != 0; i++) @(posedge mclk);
    if (host.exp_q.size() != 0)
      miscompares++;
    results();
  end
  initial begin
    #100000;
    miscompares++;
    results();
  end
endmodule // tb_pci_target_config_control
`default_nettype wire
